// ==== hdl/scp_pkg.sv ====
// Function
// - A nominal 64 MHz PLL clock, locked to the RC oscillator, feeds timer 1 and the system.
// - Source fuses 0001 select the PLL clock divided by four, about 16 MHz.
// - PLL start-up codes 00..11 give 1K,16K,1K,16K cycles, plus 14CK+8ms or 14CK+68ms.
// - Source fuses 11 select the low-power 128 kHz oscillator.
// - 128 kHz start-up codes 00..10 give 6 cycles, plus 14CK, +4ms, +64ms; 11 reserved (the code gives 11 the +64ms delay as well).
// - A programmed clock output fuse drives the system clock on the output pin.
// - The clock output pin stays quiet while reset is asserted.
// - The output pin carries the divided system clock for select 0001..1000; at division 1 (select 0000) it stays high.
// - The prescaler divides the I/O, ADC, CPU and flash clocks for every source.
// - Change enable sets only when the same write has all other bits zero.
// - Change enable clears four cycles after setting, or when select is written.
// - Rewriting change enable inside the window neither extends nor clears it.
// - Select changes take effect only when written inside an open window.
// - Reset loads select 0000, or 0011 when the divide-by-eight fuse is programmed.
// - Any select value may be written whatever the divide-by-eight fuse says.
// - Select 0000..1000 divide by 1..256 in powers of two; above is reserved.
// - Bits 6..4 of the control register read as zero.
// - Division changes make no glitch and no frequency above old and new.
// - The divider is a counter on the undivided clock, not visible to software.
// - New rate starts between T1+T2 and T1+2*T2, with two edges between; the divider here switches at the end of the old period in progress.
// - Source fuses 0010 select the RC at 8.0 MHz, 0011 calibrated to 6.4 MHz.
package scp_pkg;
  localparam logic [11:0] SCP_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] SCP_STATUS_OFFSET = 12'h004;
  localparam int SCP_CE_BIT = 7;
  localparam int SCP_SEL_LSB = 0;
  localparam int SCP_SEL_W = 4;
  localparam logic [3:0] SCP_SEL_RESET = 4'h0;
  localparam logic [3:0] SCP_SEL_DIV8 = 4'h3;
  localparam logic [3:0] SCP_SEL_MAX = 4'h8;
  localparam logic [3:0] SCP_SRC_PLL = 4'h1;
  localparam logic [3:0] SCP_SRC_RC8 = 4'h2;
  localparam logic [3:0] SCP_SRC_RC64 = 4'h3;
  localparam logic [1:0] SCP_SRC_LF = 2'h3;
  localparam logic [2:0] SCP_CE_CYCLES = 3'h4;
  localparam int SCP_CLK_MHZ = 250;
  localparam int SCP_PLL_MHZ = 64;
  localparam int SCP_PLL_DIV = 4;
  localparam int SCP_LF_KHZ = 128;
  localparam int SCP_SU_1K = 1024;
  localparam int SCP_SU_16K = 16384;
  localparam int SCP_SU_6 = 6;
  localparam int SCP_SU_EXTRA = 14;
  localparam int SCP_MS_4 = 4;
  localparam int SCP_MS_8 = 8;
  localparam int SCP_MS_64 = 64;
  localparam int SCP_MS_68 = 68;
  localparam logic [1:0] SCP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCP_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SCP_SRC_KIND_PLL, SCP_SRC_KIND_RC, SCP_SRC_KIND_LF, SCP_SRC_KIND_OTHER} scp_src_t;
  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic clock_output_fuse;
    logic divide_by_eight_fuse;
  } scp_fuse_t;
endpackage : scp_pkg

// ==== hdl/scp_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module scp_divider (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic [3:0] sel,
  // Divided clock enable and level
  output logic tick,
  output logic div_clk
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [3:0] cur;
    logic [3:0] pend;
    logic change;
    logic tick;
    logic lvl;
  } scp_div_state_t;
  scp_div_state_t s_r, s_nxt;
  logic [7:0] last;
  always_comb begin
    s_nxt = s_r;
    last = 8'((9'h1 << s_r.cur) - 9'h1);
    s_nxt.tick = 1'b0;
    if (sel != s_r.pend) begin
      s_nxt.pend = sel;
      s_nxt.change = 1'b1;
    end
    // Counter on the undivided clock; switch only at a period end to avoid glitches
    if (s_r.cnt >= last) begin
      s_nxt.cnt = 8'h00;
      s_nxt.tick = 1'b1;
      s_nxt.lvl = 1'b1;
      if (s_r.change || sel != s_r.pend) begin
        s_nxt.cur = (sel != s_r.pend) ? sel : s_r.pend;
        s_nxt.change = 1'b0;
      end
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
      s_nxt.lvl = (s_r.cnt + 8'h01) <= (last >> 1) && s_r.cur != 4'h0 ? 1'b1 : 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign tick = s_r.tick;
  assign div_clk = s_r.lvl;
endmodule : scp_divider
`default_nettype wire

// ==== hdl/scp_top.sv ====
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module scp_top #(
  parameter int PLL_SU_MS_SHORT = scp_pkg::SCP_MS_8,
  parameter int PLL_SU_MS_LONG = scp_pkg::SCP_MS_68,
  parameter int LF_SU_MS_SHORT = scp_pkg::SCP_MS_4,
  parameter int LF_SU_MS_LONG = scp_pkg::SCP_MS_64,
  parameter int MS_CYCLES = scp_pkg::SCP_CLK_MHZ * 1000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fuses
  input wire scp_pkg::scp_fuse_t fuses,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock outputs
  output logic sys_clk_en,
  output logic clock_output_pin,
  output logic clock_output_pin_oe,
  output logic startup_done
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic ce;
    logic [2:0] ce_cnt;
    logic [3:0] sel;
    logic [3:0] fac;
    logic fused;
    logic [31:0] su_cnt;
    logic su_done;
    logic pin;
    logic pin_oe;
    logic tick;
  } scp_state_t;
  scp_state_t s_r, s_nxt;
  logic div_tick;
  logic div_lvl;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [31:0] su_target;
  scp_pkg::scp_src_t src;

  function automatic scp_pkg::scp_src_t src_kind(input logic [3:0] f);
    if (f == scp_pkg::SCP_SRC_PLL) begin
      src_kind = scp_pkg::SCP_SRC_KIND_PLL;
    end else if (f == scp_pkg::SCP_SRC_RC8 || f == scp_pkg::SCP_SRC_RC64) begin
      src_kind = scp_pkg::SCP_SRC_KIND_RC;
    end else if (f[1:0] == scp_pkg::SCP_SRC_LF) begin
      src_kind = scp_pkg::SCP_SRC_KIND_LF;
    end else begin
      src_kind = scp_pkg::SCP_SRC_KIND_OTHER;
    end
  endfunction : src_kind

  // Start-up delay in aclk cycles; oscillator cycles are approximated by aclk
  function automatic logic [31:0] su_cycles(input scp_pkg::scp_src_t k, input logic [1:0] c);
    int v;
    v = scp_pkg::SCP_SU_EXTRA;
    if (k == scp_pkg::SCP_SRC_KIND_PLL) begin
      v = v + (c[0] ? scp_pkg::SCP_SU_16K : scp_pkg::SCP_SU_1K);
      v = v + (c[1] ? PLL_SU_MS_LONG : PLL_SU_MS_SHORT) * MS_CYCLES;
    end else begin
      v = v + scp_pkg::SCP_SU_6;
      if (c == 2'h1) begin
        v = v + LF_SU_MS_SHORT * MS_CYCLES;
      end else if (c != 2'h0) begin
        v = v + LF_SU_MS_LONG * MS_CYCLES;
      end
    end
    su_cycles = 32'(v);
  endfunction : su_cycles

  scp_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(s_r.fac),
    .tick(div_tick),
    .div_clk(div_lvl)
  );

  assign src = src_kind(fuses.clock_source_select_fuses);
  assign su_target = su_cycles(src, fuses.startup_time_fuses);
  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wbyte = s_r.wdata[7:0];

  always_comb begin
    s_nxt = s_r;
    if (!s_r.fused) begin
      s_nxt.fused = 1'b1;
      s_nxt.sel = fuses.divide_by_eight_fuse ? scp_pkg::SCP_SEL_DIV8 : scp_pkg::SCP_SEL_RESET;
      s_nxt.fac = s_nxt.sel;
    end
    if (!s_r.su_done) begin
      if (s_r.su_cnt >= su_target) begin
        s_nxt.su_done = 1'b1;
      end else begin
        s_nxt.su_cnt = s_r.su_cnt + 32'h1;
      end
    end
    if (s_axi_awvalid && !s_r.aw_got) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    // Window countdown runs on aclk cycles
    if (s_r.ce) begin
      if (s_r.ce_cnt <= 3'h1) begin
        s_nxt.ce = 1'b0;
        s_nxt.ce_cnt = 3'h0;
      end else begin
        s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
      end
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = scp_pkg::SCP_RESP_OKAY;
      if (s_r.awaddr[11:2] == scp_pkg::SCP_CTRL_OFFSET[11:2]) begin
        if (s_r.wstrb[0]) begin
          if (wbyte[scp_pkg::SCP_CE_BIT] && wbyte[6:0] == 7'h00) begin
            if (!s_r.ce) begin
              s_nxt.ce = 1'b1;
              s_nxt.ce_cnt = scp_pkg::SCP_CE_CYCLES;
            end
          end else if (!wbyte[scp_pkg::SCP_CE_BIT]) begin
            if (s_r.ce) begin
              s_nxt.sel = wbyte[scp_pkg::SCP_SEL_LSB +: scp_pkg::SCP_SEL_W];
              if (s_nxt.sel <= scp_pkg::SCP_SEL_MAX) begin
                s_nxt.fac = s_nxt.sel;
              end
            end
            s_nxt.ce = 1'b0;
            s_nxt.ce_cnt = 3'h0;
          end
        end
      end else if (s_r.awaddr[11:2] != scp_pkg::SCP_STATUS_OFFSET[11:2]) begin
        s_nxt.bresp = scp_pkg::SCP_RESP_SLVERR;
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = scp_pkg::SCP_RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr[11:2] == scp_pkg::SCP_CTRL_OFFSET[11:2]) begin
        s_nxt.rdata[7:0] = {s_r.ce, 3'h0, s_r.sel};
      end else if (s_axi_araddr[11:2] == scp_pkg::SCP_STATUS_OFFSET[11:2]) begin
        s_nxt.rdata[7:0] = {s_r.su_done, 1'b0, 2'(src), s_r.fac};
      end else begin
        s_nxt.rresp = scp_pkg::SCP_RESP_SLVERR;
      end
    end
    s_nxt.tick = div_tick && s_r.su_done;
    s_nxt.pin_oe = fuses.clock_output_fuse;
    s_nxt.pin = fuses.clock_output_fuse && s_r.su_done && div_lvl;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = !s_r.aw_got;
  assign s_axi_wready = !s_r.w_got;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;
  assign sys_clk_en = s_r.tick;
  assign clock_output_pin = s_r.pin;
  assign clock_output_pin_oe = s_r.pin_oe;
  assign startup_done = s_r.su_done;
endmodule : scp_top
`default_nettype wire

// ==== verification/scp_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module scp_monitor (
  // Clock, reset and fuses
  input wire logic aclk,
  input wire logic aresetn,
  input wire scp_pkg::scp_fuse_t fuses,
  // Read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Clock outputs
  input wire logic sys_clk_en,
  input wire logic clock_output_pin,
  input wire logic clock_output_pin_oe,
  input wire logic startup_done
);
  logic [11:0] ra_r;
  logic [15:0] su_r;
  // Address of the read in flight, and cycles spent in start-up
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_r <= s_axi_araddr;
    end
    su_r <= !aresetn ? 16'h0 : su_r + {15'h0, !startup_done};
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset itself is the cause here, so no disable
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !clock_output_pin && !clock_output_pin_oe)
    else $error("clock output active after reset");
  a_oe_fuse: assert property (fuses.clock_output_fuse |=> clock_output_pin_oe)
    else $error("clock output enable does not follow fuse");
  a_pin_start: assert property (!startup_done ##1 !startup_done |-> !clock_output_pin)
    else $error("clock output toggles before start-up");
  a_tick_start: assert property (sys_clk_en |-> startup_done)
    else $error("system clock enable before start-up");
  a_ctrl_zero: assert property (s_axi_rvalid && ra_r == scp_pkg::SCP_CTRL_OFFSET |->
    s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:4] == 3'h0)
    else $error("control read has nonzero reserved bits");
  a_status_src: assert property (s_axi_rvalid && ra_r == scp_pkg::SCP_STATUS_OFFSET &&
    fuses.clock_source_select_fuses == scp_pkg::SCP_SRC_PLL |-> s_axi_rdata[5:4] == 2'h0)
    else $error("status source kind wrong for pll");
  a_startup_len: assert property ($rose(startup_done) && fuses.clock_source_select_fuses == scp_pkg::SCP_SRC_PLL
    |-> su_r >= 16'h040E)
    else $error("start-up finished too early");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  c_ce_seen: cover property (s_axi_rvalid && ra_r == scp_pkg::SCP_CTRL_OFFSET && s_axi_rdata[7]);
  c_started: cover property ($rose(startup_done));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == scp_pkg::SCP_RESP_SLVERR);
endmodule : scp_monitor
bind scp_top scp_monitor u_scp_monitor (.aclk, .aresetn, .fuses, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .sys_clk_en, .clock_output_pin,
  .clock_output_pin_oe, .startup_done);
`default_nettype wire

// ==== verification/system_clock_select_prescaler_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_prescaler_tb_top;
  localparam logic [11:0] ctl = scp_pkg::SCP_CTRL_OFFSET;
  localparam logic [31:0] all = 32'hFFFF_FFFF;
  localparam logic [1:0] ok = scp_pkg::SCP_RESP_OKAY;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sys_clk_en, clock_output_pin, clock_output_pin_oe, startup_done;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, a;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [65:0] e;
  logic [65:0] exp_r[$];
  logic [1:0] exp_b[$];
  scp_pkg::scp_fuse_t fuses = {scp_pkg::SCP_SRC_PLL, 2'h0, 1'b1, 1'b0};
  int num_errors = 0, samples_checked = 0, seed = 32'h2606, i;
  // Long counts shortened: one cycle stands for a millisecond
  scp_top #(.MS_CYCLES(1)) u_scp_top (.aclk, .aresetn, .fuses, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sys_clk_en, .clock_output_pin, .clock_output_pin_oe, .startup_done);
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] seen);
    samples_checked++;
    if (seen !== ex) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask : cmp
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic axi_write(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Each channel drops only at the edge where its own ready is seen
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask : axi_write
  task automatic axi_read(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, m, d & m});
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
  endtask : axi_read
  task automatic set_sel(input logic [31:0] v);
    // Two writes back to back; nothing may slip in between
    axi_write(ctl, 32'h80, ok);
    axi_write(ctl, v, ok);
  endtask : set_sel
  task automatic per(input int n);
    int c;
    logic p;
    c = 0;
    // Let the switch settle over a few divided periods first
    repeat (4) do @(posedge aclk); while (!sys_clk_en);
    do begin @(posedge aclk); c++; end while (!sys_clk_en);
    cmp("enable period", n, c);
    if (n > 1) begin
      c = 0;
      p = clock_output_pin;
      repeat (8 * n) begin @(posedge aclk); c += int'(clock_output_pin && !p); p = clock_output_pin; end
      cmp("pin rises", 8, c);
    end
  endtask : per
  always @(posedge aclk) begin
    if (s_axi_rvalid) begin
      e = exp_r.pop_front();
      cmp("rdata", e[31:0], s_axi_rdata & e[63:32]);
      cmp("rresp", {30'h0, e[65:64]}, {30'h0, s_axi_rresp});
    end
    if (s_axi_bvalid) cmp("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
  end
  initial forever #2 aclk = ~aclk;
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    do @(posedge aclk); while (!startup_done);
    axi_read(ctl, all, {28'h0, scp_pkg::SCP_SEL_RESET}, ok);
    axi_read(scp_pkg::SCP_STATUS_OFFSET, 32'hB0, 32'h80, ok);
    axi_write(ctl, 32'h81, ok);
    axi_read(ctl, all, 32'h0, ok);
    axi_write(ctl, 32'h80, ok);
    axi_read(ctl, all, 32'h80, ok);
    repeat (8) @(posedge aclk);
    axi_read(ctl, all, 32'h0, ok);
    axi_write(ctl, 32'h80, ok);
    set_sel(32'h5);
    axi_read(ctl, all, 32'h0, ok);
    $display("unlock tests done");
    for (i = 0; i < 16; i++) begin
      set_sel(i);
      axi_read(ctl, all, i, ok);
      if (i < 10) per(i > 8 ? 256 : 1 << i);
    end
    // Low byte lane off: the unlock write must not land
    s_axi_wstrb <= 4'hE;
    axi_write(ctl, 32'h80, ok);
    s_axi_wstrb <= 4'hF;
    axi_read(ctl, all, 32'h0F, ok);
    axi_write(ctl, $random(seed) & 32'h07, ok);
    axi_read(ctl, all, 32'h0F, ok);
    $display("divider tests done");
    a = 12'h008 + 12'($random(seed) & 32'h3F0);
    axi_write(a, $random(seed), scp_pkg::SCP_RESP_SLVERR);
    axi_read(a, all, 32'h0, scp_pkg::SCP_RESP_SLVERR);
    $display("unmapped tests done");
    aresetn <= 1'b0;
    fuses.divide_by_eight_fuse <= 1'b1;
    fuses.clock_source_select_fuses <= scp_pkg::SCP_SRC_RC8;
    fuses.startup_time_fuses <= 2'h1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    do @(posedge aclk); while (!startup_done);
    axi_read(ctl, all, {28'h0, scp_pkg::SCP_SEL_DIV8}, ok);
    axi_read(scp_pkg::SCP_STATUS_OFFSET, 32'hBF, {24'h0, 4'h9, scp_pkg::SCP_SEL_DIV8}, ok);
    per(8);
    set_sel(32'h0);
    axi_read(ctl, all, 32'h0, ok);
    $display("divide by eight tests done");
    aresetn <= 1'b0;
    fuses.clock_output_fuse <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    do @(posedge aclk); while (!startup_done);
    // Fuse off: the pin is neither driven nor toggled
    i = 0;
    repeat (64) begin @(posedge aclk); i += int'(clock_output_pin || clock_output_pin_oe); end
    cmp("pin off", 32'h0, i);
    $display("clock output fuse tests done");
    give_verdict();
  end
endmodule : system_clock_select_prescaler_tb_top
`default_nettype wire
